/* File: inc/rgfm_map.vh */
// Constants for the regulator fault and mode logic.
// Assumes a 10 MHz system clock; included by the core file.
`ifndef RGFM_MAP_VH
`define RGFM_MAP_VH
`define RGFM_CLK_KHZ 10000
`define RGFM_OC_SAMPLE_NS 15000
`define RGFM_OC_SAMPLE_CYC ((`RGFM_OC_SAMPLE_NS * `RGFM_CLK_KHZ) / 1000000)
`define RGFM_OC_TRIP_COUNT 8
`define RGFM_SHORT_NS 2000
`define RGFM_SHORT_CYC ((`RGFM_SHORT_NS * `RGFM_CLK_KHZ) / 1000000)
`define RGFM_VQUAL_NS 1000000
`define RGFM_VQUAL_CYC ((`RGFM_VQUAL_NS * `RGFM_CLK_KHZ) / 1000000)
`define RGFM_AUDIO_NS 35000
`define RGFM_AUDIO_CYC ((`RGFM_AUDIO_NS * `RGFM_CLK_KHZ) / 1000000)
`define RGFM_AUDIO_PULSE_CYC 4
`define RGFM_BLANK_CYC 2
`define RGFM_MODE_COUNT 3
`define RGFM_WIN_NONE 2'h0
`define RGFM_WIN_30 2'h1
`define RGFM_WIN_50 2'h2
`endif

/* File: core/rgfm_core.v */
// Mode selection and fault protection logic of a single-phase buck regulator.
// Assumes comparator inputs already synchronous to i_mclk and free of glitches.
//
// Function
// - Heavy load: low side acts as rectifier
// - Three negative pulses enter diode emulation
// - Phase comparator latches after blanking, high off
// - Latched means negative, unlatched means positive
// - Three positive pulses return to continuous conduction
// - Window step 30, 50 or none
// - Audio filter pulses low side every 35us
// - Sample overcurrent every 15us, count up/down
// - Overcurrent fault at count eight
// - Short above 2.5x latches within 2us
// - Undervoltage after 1ms 300mV below setpoint
// - Overvoltage after 1ms 195mV above setpoint
// - Compare against slewing and settled setpoint
// - Fault forces gates and power good low
// - Fault clears on enable or bias cycling
// - Severe overvoltage: high low, low side on
// - Low side hysteresis 0.77V/1.545V until bias reset
// - Severe overvoltage armed despite other faults
// - Soft-start keeps continuous conduction
`timescale 1ns/10ps
`default_nettype none
`include "rgfm_map.vh"

module rgfm_core #(
    parameter VQUAL_CYC = `RGFM_VQUAL_CYC,
    parameter AUDIO_CYC = `RGFM_AUDIO_CYC
) (
    input wire i_mclk,
    input wire i_reset,
    input wire i_bias_por,
    input wire i_regulator_enable_input,
    input wire i_soft_start,
    input wire i_pwm,
    input wire i_phase_positive,
    input wire i_oc_over,
    input wire i_short_over,
    input wire i_uv_cmp,
    input wire i_ov_cmp,
    input wire i_sovp_high,
    input wire i_sovp_low,
    input wire i_audio_en,
    input wire [1:0] i_window_cfg,
    output reg o_high_side_gate_drive,
    output reg o_low_side_gate_drive,
    output reg o_power_good_output,
    output reg o_diode_emulation,
    output reg [1:0] o_window_step,
    output reg o_overcurrent_fault,
    output reg o_overvoltage_fault,
    output reg o_undervoltage_fault,
    output reg o_severe_ov
);

    localparam MODE_CCM = 2'b01;
    localparam MODE_DEM = 2'b10;
    localparam integer OC_SAMPLE_I = `RGFM_OC_SAMPLE_CYC;
    localparam integer SHORT_I = `RGFM_SHORT_CYC;
    localparam integer OC_TRIP_I = `RGFM_OC_TRIP_COUNT;
    localparam integer MCOUNT_I = `RGFM_MODE_COUNT;
    localparam integer BLANK_I = `RGFM_BLANK_CYC;
    localparam integer APULSE_I = `RGFM_AUDIO_PULSE_CYC;
    localparam [15:0] OC_SAMPLE = OC_SAMPLE_I[15:0];
    localparam [15:0] SHORT_CYC = SHORT_I[15:0];
    localparam [23:0] VQUAL = VQUAL_CYC[23:0];
    localparam [15:0] AUDIO = AUDIO_CYC[15:0];
    localparam [3:0] OC_TRIP = OC_TRIP_I[3:0];
    localparam [1:0] MCOUNT = MCOUNT_I[1:0];
    localparam [3:0] BLANK = BLANK_I[3:0];
    localparam [3:0] APULSE = APULSE_I[3:0];

    // ********************************
    // Clearing and fault state
    // ********************************
    // Enable low or bias reset clears ordinary faults and all counters
    wire clr = i_bias_por | ~i_regulator_enable_input;
    wire any_fault = o_overcurrent_fault | o_overvoltage_fault | o_undervoltage_fault;

    // ********************************
    // Pulse classification
    // ********************************
    reg pwm_d_r;
    reg [3:0] blank_r;
    reg phase_lat_r;
    reg [1:0] neg_cnt_r;
    reg [1:0] pos_cnt_r;
    reg [1:0] mode_r;
    wire pulse_start = i_pwm & ~pwm_d_r;
    always @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            pwm_d_r <= 1'b0;
            blank_r <= 4'h0;
            phase_lat_r <= 1'b0;
            neg_cnt_r <= 2'h0;
            pos_cnt_r <= 2'h0;
            mode_r <= MODE_CCM;
        end else if (clr) begin
            pwm_d_r <= 1'b0;
            blank_r <= 4'h0;
            phase_lat_r <= 1'b0;
            neg_cnt_r <= 2'h0;
            pos_cnt_r <= 2'h0;
            mode_r <= MODE_CCM;
        end else begin
            pwm_d_r <= i_pwm;
            if (!i_pwm && pwm_d_r)
                blank_r <= BLANK;
            else if (blank_r != 4'h0)
                blank_r <= blank_r - 4'h1;
            // First low cycle still sees the high side on, so it is blanked too
            if (!i_pwm && !pwm_d_r && blank_r == 4'h0 && i_phase_positive)
                phase_lat_r <= 1'b1;
            if (pulse_start) begin
                phase_lat_r <= 1'b0;
                if (phase_lat_r) begin
                    pos_cnt_r <= 2'h0;
                    if (neg_cnt_r != MCOUNT)
                        neg_cnt_r <= neg_cnt_r + 2'h1;
                end else begin
                    neg_cnt_r <= 2'h0;
                    if (pos_cnt_r != MCOUNT)
                        pos_cnt_r <= pos_cnt_r + 2'h1;
                end
            end
            case (mode_r)
                MODE_CCM: begin
                    // Soft-start holds continuous conduction
                    if (!i_soft_start && neg_cnt_r == MCOUNT) begin
                        mode_r <= MODE_DEM;
                        pos_cnt_r <= 2'h0;
                    end
                end
                MODE_DEM: begin
                    if (i_soft_start || pos_cnt_r == MCOUNT) begin
                        mode_r <= MODE_CCM;
                        neg_cnt_r <= 2'h0;
                    end
                end
                default: mode_r <= MODE_CCM;
            endcase
        end
    end
    wire diode_emulation = (mode_r == MODE_DEM);

    // ********************************
    // Audio filter timer
    // ********************************
    reg [15:0] audio_cnt_r;
    reg [3:0] apulse_r;
    always @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            audio_cnt_r <= 16'h0;
            apulse_r <= 4'h0;
        end else if (!diode_emulation || !i_audio_en || clr) begin
            audio_cnt_r <= 16'h0;
            apulse_r <= 4'h0;
        end else begin
            if (i_pwm || audio_cnt_r == AUDIO - 16'h1) begin
                audio_cnt_r <= 16'h0;
                if (!i_pwm)
                    apulse_r <= APULSE;
            end else begin
                audio_cnt_r <= audio_cnt_r + 16'h1;
            end
            if (apulse_r != 4'h0 && !(audio_cnt_r == AUDIO - 16'h1))
                apulse_r <= apulse_r - 4'h1;
        end
    end

    // ********************************
    // Overcurrent counter and short filter
    // ********************************
    reg [15:0] oc_tick_r;
    reg [3:0] oc_cnt_r;
    reg [15:0] short_cnt_r;
    always @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            oc_tick_r <= 16'h0;
            oc_cnt_r <= 4'h0;
            short_cnt_r <= 16'h0;
        end else if (clr) begin
            oc_tick_r <= 16'h0;
            oc_cnt_r <= 4'h0;
            short_cnt_r <= 16'h0;
        end else begin
            if (oc_tick_r == OC_SAMPLE - 16'h1) begin
                oc_tick_r <= 16'h0;
                if (i_oc_over && oc_cnt_r != OC_TRIP)
                    oc_cnt_r <= oc_cnt_r + 4'h1;
                else if (!i_oc_over && oc_cnt_r != 4'h0)
                    oc_cnt_r <= oc_cnt_r - 4'h1;
            end else begin
                oc_tick_r <= oc_tick_r + 16'h1;
            end
            // Short confirmation one cycle inside the limit, rejects one-cycle spikes
            if (!i_short_over)
                short_cnt_r <= 16'h0;
            else if (short_cnt_r != SHORT_CYC)
                short_cnt_r <= short_cnt_r + 16'h1;
        end
    end

    // ********************************
    // Voltage qualification timers
    // ********************************
    // Comparators see the live setpoint, ramping or settled
    reg [23:0] uv_cnt_r;
    reg [23:0] ov_cnt_r;
    always @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            uv_cnt_r <= 24'h0;
            ov_cnt_r <= 24'h0;
        end else if (clr) begin
            uv_cnt_r <= 24'h0;
            ov_cnt_r <= 24'h0;
        end else begin
            uv_cnt_r <= !i_uv_cmp ? 24'h0 :
                (uv_cnt_r != VQUAL ? uv_cnt_r + 24'h1 : uv_cnt_r);
            ov_cnt_r <= !i_ov_cmp ? 24'h0 :
                (ov_cnt_r != VQUAL ? ov_cnt_r + 24'h1 : ov_cnt_r);
        end
    end

    // ********************************
    // Fault latches
    // ********************************
    always @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_overcurrent_fault <= 1'b0;
            o_overvoltage_fault <= 1'b0;
            o_undervoltage_fault <= 1'b0;
        end else if (clr) begin
            o_overcurrent_fault <= 1'b0;
            o_overvoltage_fault <= 1'b0;
            o_undervoltage_fault <= 1'b0;
        end else begin
            if (oc_cnt_r == OC_TRIP)
                o_overcurrent_fault <= 1'b1;
            if (i_short_over && short_cnt_r == SHORT_CYC - 16'h2)
                o_overcurrent_fault <= 1'b1;
            if (uv_cnt_r == VQUAL)
                o_undervoltage_fault <= 1'b1;
            if (ov_cnt_r == VQUAL)
                o_overvoltage_fault <= 1'b1;
        end
    end

    // ********************************
    // Severe overvoltage
    // ********************************
    // Only the bias reset clears it, enable cycling does not
    reg sovp_lg_r;
    always @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_severe_ov <= 1'b0;
            sovp_lg_r <= 1'b0;
        end else if (i_bias_por) begin
            o_severe_ov <= 1'b0;
            sovp_lg_r <= 1'b0;
        end else begin
            if (i_sovp_high) begin
                o_severe_ov <= 1'b1;
                sovp_lg_r <= 1'b1;
            end else if (i_sovp_low) begin
                sovp_lg_r <= 1'b0;
            end
        end
    end

    // ********************************
    // Gate and status outputs
    // ********************************
    always @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_high_side_gate_drive <= 1'b0;
            o_low_side_gate_drive <= 1'b0;
            o_power_good_output <= 1'b0;
            o_diode_emulation <= 1'b0;
            o_window_step <= `RGFM_WIN_NONE;
        end else begin
            o_diode_emulation <= diode_emulation;
            o_window_step <= diode_emulation ? i_window_cfg : `RGFM_WIN_NONE;
            if (o_severe_ov || i_sovp_high) begin
                o_high_side_gate_drive <= 1'b0;
                // Low threshold releases the low side on the same edge
                o_low_side_gate_drive <= i_sovp_high | (sovp_lg_r & ~i_sovp_low);
                o_power_good_output <= 1'b0;
            end else if (any_fault || clr) begin
                o_high_side_gate_drive <= 1'b0;
                o_low_side_gate_drive <= 1'b0;
                o_power_good_output <= 1'b0;
            end else begin
                o_high_side_gate_drive <= i_pwm;
                // Diode emulation: low side only for audio pulses
                o_low_side_gate_drive <= ~i_pwm & (~diode_emulation | (apulse_r != 4'h0));
                o_power_good_output <= ~i_soft_start;
            end
        end
    end

endmodule
`default_nettype wire

/* File: test/rgfm_assertions.sv */
// Checker for the regulator fault and mode logic.
// Bound onto rgfm_core by the bench; sees that module's ports only.
`timescale 1ns/10ps
`default_nettype none
module rgfm_chk #(
    parameter VQUAL_CYC = 50,
    parameter AUDIO_CYC = 20
) (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_bias_por,
    input wire logic i_regulator_enable_input,
    input wire logic i_soft_start,
    input wire logic i_short_over,
    input wire logic i_sovp_high,
    input wire logic i_sovp_low,
    input wire logic o_high_side_gate_drive,
    input wire logic o_low_side_gate_drive,
    input wire logic o_power_good_output,
    input wire logic o_diode_emulation,
    input wire logic [1:0] o_window_step,
    input wire logic o_overcurrent_fault,
    input wire logic o_overvoltage_fault,
    input wire logic o_undervoltage_fault,
    input wire logic o_severe_ov
);
    // ***
    // Properties
    // ***
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_reset);
    wire flt = o_overcurrent_fault | o_overvoltage_fault | o_undervoltage_fault;
    AST_FAULT_OFF: assert property (flt && !o_severe_ov && !i_sovp_high |=>
        !o_high_side_gate_drive && !o_low_side_gate_drive && !o_power_good_output)
        else $error("gates or power good on in fault");
    AST_SOV_ENTER: assert property (i_sovp_high && !i_sovp_low && !i_bias_por |=>
        o_severe_ov && o_low_side_gate_drive && !o_high_side_gate_drive
        && !o_power_good_output) else $error("severe overvoltage entry wrong");
    AST_SOV_OVER: assert property (flt && i_sovp_high && !i_bias_por |=>
        o_severe_ov) else $error("severe overvoltage masked by fault");
    AST_SOV_LOW: assert property (o_severe_ov && i_sovp_low && !i_sovp_high
        && !i_bias_por |=> o_severe_ov && !o_low_side_gate_drive)
        else $error("severe low side not released");
    AST_SOFT_CCM: assert property (i_soft_start [*3] |-> !o_diode_emulation)
        else $error("diode emulation in soft start");
    AST_WIN_CCM: assert property (!o_diode_emulation ##1 !o_diode_emulation |->
        o_window_step == 2'h0) else $error("window step outside diode emulation");
    AST_SHORT: assert property ($rose(i_short_over) && i_regulator_enable_input |->
        ##[1:21] (o_overcurrent_fault || !i_short_over || !i_regulator_enable_input
        || i_bias_por)) else $error("short not latched in time");
    AST_HOLD: assert property (o_overcurrent_fault && i_regulator_enable_input
        && !i_bias_por |=> o_overcurrent_fault) else $error("fault dropped");
    cover property ($rose(o_diode_emulation));
    cover property ($rose(o_severe_ov));
    cover property ($rose(o_undervoltage_fault));
endmodule
`default_nettype wire

/* File: test/rgfm_plant.sv */
// Power stage model: phase comparator as seen from the switch node.
// Assumes the bench picks the load level through i_light.
`timescale 1ns/10ps
`default_nettype none
module rgfm_plant (
    input wire logic i_hs,
    input wire logic i_light,
    output logic o_phase_positive
);
    // ***
    // Phase node
    // ***
    // High side pulls node to input rail; light load reverses current once off
    assign o_phase_positive = i_hs | i_light;
endmodule
`default_nettype wire

/* File: test/rgfm_core_tb.sv */
// Self-checking bench for rgfm_core with a power stage model.
// Assumes shortened qualification and audio counts set below.
`timescale 1ns/10ps
`default_nettype none
module rgfm_core_tb;
    // ***
    // Signals and instances
    // ***
    logic i_mclk = 0, i_reset = 1, i_bias_por = 0, i_regulator_enable_input = 1;
    logic i_soft_start = 0, i_pwm = 0, i_phase_positive, i_oc_over = 0, i_short_over = 0;
    logic i_uv_cmp = 0, i_ov_cmp = 0, i_sovp_high = 0, i_sovp_low = 0, i_audio_en = 0;
    logic [1:0] i_window_cfg = 0, o_window_step;
    logic o_high_side_gate_drive, o_low_side_gate_drive, o_power_good_output;
    logic o_diode_emulation, o_overcurrent_fault, o_overvoltage_fault, o_undervoltage_fault;
    logic o_severe_ov, light = 0;
    int mismatches = 0, comparisons = 0, n;
    logic [19:0] exp_q[$];
    bit pat[5] = '{1, 1, 0, 1, 1};
    event smp;
    localparam logic [9:0] k_hs = 10'h200, k_ls = 10'h100, k_pg = 10'h080, k_dm = 10'h040;
    localparam logic [9:0] k_wn = 10'h030, k_oc = 10'h008, k_ov = 10'h004, k_uv = 10'h002;
    localparam logic [9:0] k_sv = 10'h001;
    wire [9:0] obs = {o_high_side_gate_drive, o_low_side_gate_drive, o_power_good_output,
        o_diode_emulation, o_window_step, o_overcurrent_fault, o_overvoltage_fault,
        o_undervoltage_fault, o_severe_ov};
    rgfm_core #(.VQUAL_CYC(50), .AUDIO_CYC(20)) dut (.*);
    rgfm_plant u_plant (.i_hs(o_high_side_gate_drive), .i_light(light),
        .o_phase_positive(i_phase_positive));
    initial forever #50 i_mclk = ~i_mclk;
    // ***
    // Tasks and monitor
    // ***
    task automatic check(input logic [9:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic step(input int c);
        repeat (c) @(posedge i_mclk);
        #5;
    endtask
    task automatic expect_out(input logic [9:0] m, v);
        exp_q.push_back({m, v});
        -> smp;
        step(1);
    endtask
    // Off phase judged at the following rise; widths random
    task automatic pulse(input logic l);
        light = l;
        i_pwm = 0;
        step(6 + $urandom % 4);
        i_pwm = 1;
        step(5 + $urandom % 3);
    endtask
    initial begin : mon
        logic [19:0] e;
        forever begin
            @(smp);
            e = exp_q.pop_front();
            check(obs & e[19:10], e[9:0]);
        end
    end
    initial begin
        #2000000;
        mismatches++;
        print_verdict;
    end
    // ***
    // Scenarios
    // ***
    initial begin
        n = $urandom(32'hdcc207cc);
        step(1);
        expect_out(10'h3ff, 10'h000);
        step(10);
        i_reset = 0;
        step(2);
        pulse(0);
        expect_out(k_hs | k_ls | k_pg | k_dm, k_hs | k_pg);
        i_pwm = 0;
        step(3);
        expect_out(k_hs | k_ls | k_dm, k_ls);
        i_soft_start = 1;
        repeat (4) pulse(1);
        expect_out(k_pg | k_dm, 10'h000);
        i_soft_start = 0;
        $display("test conduction and soft start done");
        for (int c = 0; c < 3; c++) begin
            i_window_cfg = c[1:0];
            i_audio_en = c[0];
            repeat (3) pulse(0);
            foreach (pat[j]) pulse(pat[j]);
            expect_out(k_dm | k_wn, 10'h000);
            pulse(1);
            expect_out(k_dm | k_wn, k_dm | (10'(c) << 4));
            i_pwm = 0;
            light = 0;
            step(10);
            n = 0;
            repeat (60) begin
                step(1);
                n += o_low_side_gate_drive;
            end
            check({9'h0, n > 0}, {9'h0, c[0]});
            repeat (3) pulse(0);
            expect_out(k_dm | k_wn, 10'h000);
            $display("test mode cfg %0d done", c);
        end
        i_pwm = 0;
        i_oc_over = 1;
        step(900);
        expect_out(k_oc, 10'h000);
        i_oc_over = 0;
        step(1500);
        i_oc_over = 1;
        step(900);
        expect_out(k_oc, 10'h000);
        step(450);
        expect_out(k_oc | k_hs | k_ls | k_pg, k_oc);
        i_oc_over = 0;
        i_regulator_enable_input = 0;
        step(2);
        i_regulator_enable_input = 1;
        step(1);
        expect_out(k_oc, 10'h000);
        $display("test overcurrent done");
        i_short_over = 1;
        step(21);
        expect_out(k_oc, k_oc);
        i_short_over = 0;
        i_sovp_high = 1;
        step(1);
        expect_out(k_sv | k_hs | k_ls | k_pg | k_oc, k_sv | k_ls | k_oc);
        i_sovp_high = 0;
        i_sovp_low = 1;
        step(2);
        expect_out(k_sv | k_ls, k_sv);
        i_sovp_low = 0;
        i_sovp_high = 1;
        i_regulator_enable_input = 0;
        step(2);
        i_regulator_enable_input = 1;
        step(1);
        expect_out(k_sv | k_ls | k_hs, k_sv | k_ls);
        i_sovp_high = 0;
        i_bias_por = 1;
        step(2);
        i_bias_por = 0;
        step(1);
        expect_out(k_sv | k_oc, 10'h000);
        $display("test short and severe overvoltage done");
        for (int v = 0; v < 2; v++) begin
            i_soft_start = v[0];
            {i_uv_cmp, i_ov_cmp} = v ? 2'h1 : 2'h2;
            step(40);
            {i_uv_cmp, i_ov_cmp} = 2'h0;
            step(1);
            {i_uv_cmp, i_ov_cmp} = v ? 2'h1 : 2'h2;
            step(40);
            expect_out(k_uv | k_ov, 10'h000);
            step(20);
            expect_out(k_uv | k_ov, v ? k_ov : k_uv);
            {i_uv_cmp, i_ov_cmp} = 2'h0;
            i_regulator_enable_input = 0;
            step(2);
            i_regulator_enable_input = 1;
            $display("test voltage window %0d done", v);
        end
        step(2);
        print_verdict;
    end
endmodule
bind rgfm_core rgfm_chk #(.VQUAL_CYC(VQUAL_CYC), .AUDIO_CYC(AUDIO_CYC)) u_chk (.*);
`default_nettype wire
